// ==== hdl/wkh_ctrl.sv ====
// keepalive sequence and filter command block: software loads command
// arguments over the register port, then writes the command code.
// assumes an outside parser has split the command text into fields.
//
// Summary of operation
// - bad command returns numbered error code one-ten
// - iso period counts 20 ms steps, XX default
// - period hex; 64 gives 2000 ms spacing
// - eight stored iso sequences, each protocol linked
// - slot zero temporary, one to eight stored
// - protocol 101 to 140, XX means any
// - iso data holds one to five bytes
// - iso control zero disables, one enables
// - new sequence starts now if protocol matches
// - can delete clears slot, stops running sequence
// - iso delete of running falls to default
// - delete slot zero or none removes temporary
// - show slot, zero current, F lists all
// - show lists fields; empty slot gives marker
// - filter and mask share format and extension
// - accept 11bit, 29bit, extension, six-digit non-can
// - separate 11-bit and 29-bit filter sets
// - unlinked temporary can runs on 11-bit only
// - temporary settings vanish at reset
// - can header XX uses request header
// - can mode 0,1,2,9,A; bit3 follows header
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module wkh_ctrl
  import wkh_pkg::*;
#(
  parameter int unsigned STEP_CYC = KA_STEP_CYC
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // command answer
  output logic o_ok,
  output logic o_prompt,
  // keepalive transmit requests
  output wkh_ka_t o_can_ka,
  output wkh_ka_t o_iso_ka,
  // receive filters
  output wkh_filt_t o_filt11,
  output wkh_filt_t o_filt29,
  output wkh_filt_t o_filtnc
);

  // ==========================================================
  // helpers
  function automatic logic proto_range(input logic [7:0] p);
    return (p >= PROTO_MIN) && (p <= PROTO_MAX);
  endfunction

  function automatic logic dig_ok(input logic [3:0] d);
    return (d == DIG_11) || (d == DIG_NC) || (d == DIG_29);
  endfunction

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_CHECK = 3'b011,
    ST_PROMPT = 3'b010
  } wkh_state_t;

  wkh_state_t state_q;
  wkh_cmd_t cmd_q;
  logic [31:0] slot_q, proto_q, hdr_q, dlo_q, dhi_q, misc_q, mask_q, maskx_q;
  logic [31:0] ctx_q;
  logic [28:0] req_hdr_q;
  logic [39:0] pdef_q;
  logic [7:0] iso_defper_q, can_defper_q;
  logic [3:0] err_q;
  logic ok_q, empty_q, more_q;
  logic [3:0] cursor_q;
  logic [31:0] valid_q;
  wkh_entry_t show_q;
  wkh_entry_t can_act_q, iso_act_q;
  logic can_act_en_q, iso_act_en_q, iso_dflt_q;
  logic [3:0] can_act_slot_q, iso_act_slot_q;
  logic [31:0] rdata_q;

  // ==========================================================
  // decoded arguments
  logic [3:0] a_slot, a_slot_eff, a_count, a_mode, a_dig;
  logic [7:0] a_proto, a_period;
  logic a_proto_xx, a_hdr_xx, a_per_xx, a_nocomma, is_iso;
  logic [5:0] pidx;
  logic [4:0] tgt_addr, rd_addr;
  wkh_entry_t new_e, mem_rdata;
  logic [3:0] chk_err;
  logic cond_new;

  assign a_slot = slot_q[3:0];
  assign a_slot_eff = slot_q[SLOT_GIVEN_BIT] ? a_slot : 4'h0;
  assign a_proto = proto_q[7:0];
  assign a_proto_xx = proto_q[PROTO_XX_BIT];
  assign a_count = misc_q[3:0];
  assign a_period = misc_q[MISC_PER_LSB +: 8];
  assign a_per_xx = misc_q[MISC_PER_XX_BIT];
  assign a_mode = misc_q[MISC_MODE_LSB +: 4];
  assign a_hdr_xx = misc_q[MISC_HDR_XX_BIT];
  assign a_dig = misc_q[MISC_DIG_LSB +: 4];
  assign a_nocomma = misc_q[MISC_NOCOMMA_BIT];
  assign is_iso = (cmd_q == CMD_ISO_SET) || (cmd_q == CMD_ISO_DEL)
    || (cmd_q == CMD_ISO_SHOW);
  assign pidx = 6'(a_proto - PROTO_MIN);
  assign tgt_addr = {is_iso, a_slot_eff};

  always_comb begin
    new_e.proto_xx = a_proto_xx;
    new_e.proto = a_proto;
    new_e.hdr_xx = a_hdr_xx;
    new_e.hdr = hdr_q[28:0];
    new_e.data = {dhi_q, dlo_q};
    new_e.count = a_count;
    // XX period takes the stored default parameter
    new_e.period = a_per_xx ? (is_iso ? iso_defper_q : can_defper_q)
      : a_period;
    new_e.mode = a_mode;
  end

  // ==========================================================
  // parameter checking, first failing check wins
  always_comb begin
    chk_err = ERR_NONE;
    case (cmd_q)
      CMD_CAN_SET, CMD_ISO_SET: begin
        if (a_nocomma) begin
          chk_err = ERR_COMMA;
        end else if (slot_q[SLOT_BAD_BIT] || a_slot > SLOT_MAX) begin
          chk_err = ERR_NUM_INPUT;
        end else if (proto_q[PROTO_BAD_BIT]
            || (!a_proto_xx && !proto_range(a_proto))) begin
          chk_err = ERR_PROTO_INPUT;
        end else if (!a_proto_xx && !pdef_q[pidx]) begin
          chk_err = ERR_PROTO_MISSING;
        end else if (cmd_q == CMD_CAN_SET && a_proto_xx
            && a_slot != 4'h0) begin
          chk_err = ERR_PROTO_TYPE;
        end else if (cmd_q == CMD_CAN_SET
            ? (!a_hdr_xx && !dig_ok(a_dig))
            : (a_hdr_xx || a_dig != DIG_NC)) begin
          chk_err = ERR_HDR_FMT;
        end else if (a_count == 4'h0 || a_count > (cmd_q == CMD_ISO_SET
            ? ISO_DATA_MAX : CAN_DATA_MAX)) begin
          chk_err = ERR_DATA_CNT;
        end else if (!a_per_xx && a_period == 8'h00) begin
          chk_err = ERR_CYCLE;
        end else if (cmd_q == CMD_CAN_SET
            ? !(a_mode inside {4'h0, 4'h1, 4'h2, 4'h9, 4'hA})
            : (a_mode > 4'h1)) begin
          chk_err = ERR_MODE;
        end else if (a_slot != 4'h0 && valid_q[tgt_addr]) begin
          chk_err = ERR_NUM_EXISTS;
        end
      end
      CMD_CAN_DEL, CMD_ISO_DEL: begin
        if (slot_q[SLOT_BAD_BIT] || a_slot_eff > SLOT_MAX) begin
          chk_err = ERR_NUM_INPUT;
        end
      end
      CMD_CAN_SHOW, CMD_ISO_SHOW: begin
        if (slot_q[SLOT_BAD_BIT]
            || (a_slot_eff > SLOT_MAX && a_slot_eff != SLOT_ALL)) begin
          chk_err = ERR_NUM_INPUT;
        end
      end
      CMD_FILT_SET: begin
        if (a_nocomma) begin
          chk_err = ERR_COMMA;
        end else if (!dig_ok(a_dig) || a_dig != maskx_q[3:0]
            || misc_q[MISC_EXT_BIT] != maskx_q[MASKX_EXT_BIT]
            || (a_dig == DIG_NC && misc_q[MISC_EXT_BIT])) begin
          chk_err = ERR_HDR_FMT;
        end
      end
      default: chk_err = ERR_NONE;
    endcase
  end

  // linking condition of a freshly set sequence
  assign cond_new = ctx_q[CTX_ACTIVE_BIT] && (a_proto_xx
    ? (is_iso || ctx_q[CTX_CAN11_BIT]) : (a_proto == ctx_q[7:0]));

  logic exec_ok;
  assign exec_ok = (state_q == ST_CHECK) && (chk_err == ERR_NONE);

  // ==========================================================
  // sequencer
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_wr && (i_addr == REG_CMD || (i_addr == REG_SHOW_NEXT
              && more_q))) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: state_q <= ST_CHECK;
        ST_CHECK: state_q <= exec_ok ? ST_PROMPT : ST_IDLE;
        ST_PROMPT: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ok in the cycle after checking, prompt one cycle later
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_ok <= 1'b0;
      o_prompt <= 1'b0;
    end else begin
      o_ok <= exec_ok;
      o_prompt <= (state_q == ST_PROMPT);
    end
  end

  // ==========================================================
  // argument and context registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cmd_q <= CMD_NONE;
      {slot_q, proto_q, hdr_q, dlo_q, dhi_q} <= '0;
      {misc_q, mask_q, maskx_q, ctx_q} <= '0;
      pdef_q <= '0;
      req_hdr_q <= REQ_HDR_RST;
      iso_defper_q <= ISO_DEF_PERIOD_RST;
      can_defper_q <= CAN_DEF_PERIOD_RST;
    end else if (i_wr && state_q == ST_IDLE) begin
      case (i_addr)
        REG_CMD: cmd_q <= wkh_cmd_t'(i_wdata[2:0]);
        REG_SLOT: slot_q <= i_wdata;
        REG_PROTO: proto_q <= i_wdata;
        REG_HDR: hdr_q <= i_wdata;
        REG_DLO: dlo_q <= i_wdata;
        REG_DHI: dhi_q <= i_wdata;
        REG_MISC: misc_q <= i_wdata;
        REG_MASK: mask_q <= i_wdata;
        REG_MASKX: maskx_q <= i_wdata;
        REG_CTX: ctx_q <= i_wdata;
        REG_REQHDR: req_hdr_q <= i_wdata[28:0];
        REG_PDEF_LO: pdef_q[31:0] <= i_wdata;
        REG_PDEF_HI: pdef_q[39:32] <= i_wdata[7:0];
        REG_DEFPER: begin
          iso_defper_q <= i_wdata[7:0];
          can_defper_q <= i_wdata[DEFPER_CAN_LSB +: 8];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // slot occupancy; reset empties every slot
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      valid_q <= '0;
    end else if (exec_ok) begin
      case (cmd_q)
        CMD_CAN_SET, CMD_ISO_SET: valid_q[tgt_addr] <= 1'b1;
        CMD_CAN_DEL, CMD_ISO_DEL: valid_q[tgt_addr] <= 1'b0;
        default: ;
      endcase
    end
  end

  // failed checks never reach a write enable
  assign rd_addr = (cmd_q inside {CMD_CAN_SHOW, CMD_ISO_SHOW}
    && a_slot_eff == SLOT_ALL) ? {is_iso, cursor_q} : tgt_addr;

  wkh_seq_mem u_mem (
    .i_core_clk(i_core_clk),
    .i_we(exec_ok && (cmd_q == CMD_CAN_SET || cmd_q == CMD_ISO_SET)),
    .i_waddr(tgt_addr),
    .i_wdata(new_e),
    .i_raddr(rd_addr),
    .o_rdata(mem_rdata)
  );

  // ==========================================================
  // show results; F walks slots one to eight
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      show_q <= '0;
      empty_q <= 1'b0;
      more_q <= 1'b0;
      cursor_q <= 4'h1;
    end else if (exec_ok && cmd_q inside {CMD_CAN_SHOW, CMD_ISO_SHOW}) begin
      show_q <= mem_rdata;
      empty_q <= !valid_q[rd_addr];
      if (a_slot_eff == SLOT_ALL && cursor_q < SLOT_MAX) begin
        more_q <= 1'b1;
        cursor_q <= cursor_q + 4'h1;
      end else begin
        more_q <= 1'b0;
        cursor_q <= 4'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      err_q <= ERR_NONE;
      ok_q <= 1'b0;
    end else if (state_q == ST_CHECK) begin
      err_q <= chk_err;
      ok_q <= (chk_err == ERR_NONE);
    end
  end

  // ==========================================================
  // running sequences
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      can_act_q <= '0;
      can_act_en_q <= 1'b0;
      can_act_slot_q <= 4'h0;
    end else if (exec_ok && cmd_q == CMD_CAN_SET && cond_new) begin
      can_act_q <= new_e;
      can_act_en_q <= 1'b1;
      can_act_slot_q <= a_slot_eff;
    end else if (exec_ok && cmd_q == CMD_CAN_DEL
        && a_slot_eff == can_act_slot_q) begin
      can_act_en_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      iso_act_q <= '0;
      iso_act_en_q <= 1'b0;
      iso_dflt_q <= 1'b0;
      iso_act_slot_q <= 4'h0;
    end else if (exec_ok && cmd_q == CMD_ISO_SET && cond_new) begin
      iso_act_q <= new_e;
      iso_act_en_q <= a_mode[0];
      iso_dflt_q <= 1'b0;
      iso_act_slot_q <= a_slot_eff;
    end else if (exec_ok && cmd_q == CMD_ISO_DEL
        && a_slot_eff == iso_act_slot_q && iso_act_en_q) begin
      iso_act_q.period <= iso_defper_q;
      iso_dflt_q <= 1'b1;
    end
  end

  // ==========================================================
  // 20 ms step enable and period counters
  logic [31:0] step_cnt_q;
  logic step_q;
  logic [7:0] can_cnt_q, iso_cnt_q;
  logic can_run, iso_run;

  assign can_run = can_act_en_q && ctx_q[CTX_ACTIVE_BIT]
    && (can_act_q.proto_xx ? ctx_q[CTX_CAN11_BIT]
    : can_act_q.proto == ctx_q[7:0]);
  assign iso_run = (iso_act_en_q || iso_dflt_q) && ctx_q[CTX_ACTIVE_BIT];

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      step_cnt_q <= '0;
      step_q <= 1'b0;
    end else begin
      step_q <= (step_cnt_q == STEP_CYC - 1);
      step_cnt_q <= (step_cnt_q == STEP_CYC - 1) ? '0 : step_cnt_q + 1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      can_cnt_q <= 8'h00;
      iso_cnt_q <= 8'h00;
    end else if (step_q) begin
      // a period of 0x64 steps spaces sends by 2000 ms
      can_cnt_q <= (!can_run || can_cnt_q + 8'h01 >= can_act_q.period)
        ? 8'h00 : can_cnt_q + 8'h01;
      iso_cnt_q <= (!iso_run || iso_cnt_q + 8'h01 >= iso_act_q.period)
        ? 8'h00 : iso_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_can_ka <= '0;
      o_iso_ka <= '0;
    end else begin
      o_can_ka.fire <= step_q && can_run
        && (can_cnt_q + 8'h01 >= can_act_q.period);
      o_can_ka.use_default <= 1'b0;
      // XX header or mode bit3 follows the request header
      o_can_ka.id <= (can_act_q.hdr_xx
        || (can_act_q.mode & MODE_FOLLOW_BIT) != 4'h0)
        ? req_hdr_q : can_act_q.hdr;
      o_can_ka.data <= can_act_q.data;
      o_can_ka.count <= can_act_q.count;
      o_can_ka.mode <= can_act_q.mode;
      o_iso_ka.fire <= step_q && iso_run
        && (iso_cnt_q + 8'h01 >= iso_act_q.period);
      o_iso_ka.use_default <= iso_dflt_q;
      o_iso_ka.id <= iso_act_q.hdr;
      o_iso_ka.data <= iso_act_q.data;
      o_iso_ka.count <= iso_act_q.count;
      o_iso_ka.mode <= iso_act_q.mode;
    end
  end

  // ==========================================================
  // filters, one set per identifier width
  wkh_filt_t filt_new;
  assign filt_new = '{ext_en: misc_q[MISC_EXT_BIT],
    ext: maskx_q[MASKX_EXTB_LSB +: 8], id: hdr_q[28:0],
    mask: mask_q[28:0]};

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_filt11 <= '0;
      o_filt29 <= '0;
      o_filtnc <= '0;
    end else if (exec_ok && cmd_q == CMD_FILT_SET) begin
      case (a_dig)
        DIG_11: o_filt11 <= filt_new;
        DIG_29: o_filt29 <= filt_new;
        default: o_filtnc <= filt_new;
      endcase
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      case (i_addr)
        REG_STATUS: rdata_q <= {24'h0, more_q, empty_q,
          state_q != ST_IDLE, ok_q, err_q};
        REG_CTX: rdata_q <= ctx_q;
        REG_REQHDR: rdata_q <= {3'h0, req_hdr_q};
        REG_DEFPER: rdata_q <= {16'h0, can_defper_q, iso_defper_q};
        REG_SHOW_HDR: rdata_q <= {show_q.hdr_xx, 2'h0, show_q.hdr};
        REG_SHOW_DLO: rdata_q <= show_q.data[31:0];
        REG_SHOW_DHI: rdata_q <= show_q.data[63:32];
        REG_SHOW_MISC: rdata_q <= {show_q.proto_xx, 3'h0, show_q.mode,
          show_q.proto, show_q.period, 4'h0, show_q.count};
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  assign o_rdata = rdata_q;

endmodule

// ==== hdl/wkh_pkg.sv ====
// package of the keepalive / filter command block: register map, field
// positions, reset values, command codes, error codes and carried types.
// assumes a 100 MHz core clock and a word-aligned register port.
package wkh_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned KA_STEP_MS = 20;
  localparam int unsigned KA_STEP_CYC = CLK_HZ / 1000 * KA_STEP_MS;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_SLOT = 8'h04;
  localparam logic [7:0] REG_PROTO = 8'h08;
  localparam logic [7:0] REG_HDR = 8'h0C;
  localparam logic [7:0] REG_DLO = 8'h10;
  localparam logic [7:0] REG_DHI = 8'h14;
  localparam logic [7:0] REG_MISC = 8'h18;
  localparam logic [7:0] REG_MASK = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_CTX = 8'h24;
  localparam logic [7:0] REG_REQHDR = 8'h28;
  localparam logic [7:0] REG_PDEF_LO = 8'h2C;
  localparam logic [7:0] REG_PDEF_HI = 8'h30;
  localparam logic [7:0] REG_DEFPER = 8'h34;
  localparam logic [7:0] REG_SHOW_NEXT = 8'h38;
  localparam logic [7:0] REG_SHOW_HDR = 8'h3C;
  localparam logic [7:0] REG_SHOW_DLO = 8'h40;
  localparam logic [7:0] REG_SHOW_DHI = 8'h44;
  localparam logic [7:0] REG_SHOW_MISC = 8'h48;
  localparam logic [7:0] REG_MASKX = 8'h4C;

  // ==========================================================
  // field positions
  localparam int SLOT_GIVEN_BIT = 4;
  localparam int SLOT_BAD_BIT = 5;
  localparam int PROTO_XX_BIT = 8;
  localparam int PROTO_BAD_BIT = 9;
  localparam int MISC_PER_LSB = 4;
  localparam int MISC_PER_XX_BIT = 12;
  localparam int MISC_MODE_LSB = 13;
  localparam int MISC_HDR_XX_BIT = 17;
  localparam int MISC_DIG_LSB = 18;
  localparam int MISC_NOCOMMA_BIT = 22;
  localparam int MISC_EXT_BIT = 23;
  localparam int MISC_EXTB_LSB = 24;
  localparam int MASKX_EXT_BIT = 4;
  localparam int MASKX_EXTB_LSB = 5;
  localparam int CTX_ACTIVE_BIT = 8;
  localparam int CTX_CAN11_BIT = 9;
  localparam int CTX_CAN29_BIT = 10;
  localparam int DEFPER_CAN_LSB = 8;
  localparam int ST_OK_BIT = 4;
  localparam int ST_BUSY_BIT = 5;
  localparam int ST_EMPTY_BIT = 6;
  localparam int ST_MORE_BIT = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] ISO_DEF_PERIOD_RST = 8'h64;
  localparam logic [7:0] CAN_DEF_PERIOD_RST = 8'h64;
  localparam logic [28:0] REQ_HDR_RST = 29'h000007DF;

  // ==========================================================
  // argument limits
  localparam logic [7:0] PROTO_MIN = 8'd101;
  localparam logic [7:0] PROTO_MAX = 8'd140;
  localparam logic [3:0] SLOT_MAX = 4'd8;
  localparam logic [3:0] SLOT_ALL = 4'hF;
  localparam logic [3:0] CAN_DATA_MAX = 4'd8;
  localparam logic [3:0] ISO_DATA_MAX = 4'd5;
  localparam logic [3:0] DIG_11 = 4'd3;
  localparam logic [3:0] DIG_NC = 4'd6;
  localparam logic [3:0] DIG_29 = 4'd8;
  localparam logic [3:0] MODE_FOLLOW_BIT = 4'h8;

  // ==========================================================
  // commands and error codes
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_CAN_SET = 3'h1,
    CMD_ISO_SET = 3'h2,
    CMD_CAN_DEL = 3'h3,
    CMD_ISO_DEL = 3'h4,
    CMD_CAN_SHOW = 3'h5,
    CMD_ISO_SHOW = 3'h6,
    CMD_FILT_SET = 3'h7
  } wkh_cmd_t;

  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_NUM_EXISTS = 4'h1;
  localparam logic [3:0] ERR_PROTO_TYPE = 4'h2;
  localparam logic [3:0] ERR_HDR_FMT = 4'h3;
  localparam logic [3:0] ERR_DATA_CNT = 4'h4;
  localparam logic [3:0] ERR_CYCLE = 4'h5;
  localparam logic [3:0] ERR_MODE = 4'h6;
  localparam logic [3:0] ERR_COMMA = 4'h7;
  localparam logic [3:0] ERR_NUM_INPUT = 4'h8;
  localparam logic [3:0] ERR_PROTO_INPUT = 4'h9;
  localparam logic [3:0] ERR_PROTO_MISSING = 4'hA;

  // ==========================================================
  // carried types
  typedef struct packed {
    logic proto_xx;
    logic [7:0] proto;
    logic hdr_xx;
    logic [28:0] hdr;
    logic [63:0] data;
    logic [3:0] count;
    logic [7:0] period;
    logic [3:0] mode;
  } wkh_entry_t;

  typedef struct packed {
    logic ext_en;
    logic [7:0] ext;
    logic [28:0] id;
    logic [28:0] mask;
  } wkh_filt_t;

  typedef struct packed {
    logic fire;
    logic use_default;
    logic [28:0] id;
    logic [63:0] data;
    logic [3:0] count;
    logic [3:0] mode;
  } wkh_ka_t;

endpackage

// ==== hdl/wkh_seq_mem.sv ====
// sequence store: one write port, one read port with registered data.
// assumes writes and reads come from the same core clock domain.
`timescale 1ns/1ps
module wkh_seq_mem
  import wkh_pkg::*;
(
  // clock
  input wire logic i_core_clk,
  // write side
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire wkh_entry_t i_wdata,
  // read side
  input wire logic [4:0] i_raddr,
  output wkh_entry_t o_rdata
);

  // ==========================================================
  // storage
  wkh_entry_t mem_q [32];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    o_rdata <= mem_q[i_raddr];
  end

endmodule

// ==== verification/tb_wkh_ctrl.sv ====
// bench of the keepalive / filter command block
// assumes a ten-cycle step so a period of 64h spans 1000 cycles
`timescale 1ns/1ps
module tb_wkh_ctrl;
  import wkh_pkg::*;
  typedef struct packed {
    wkh_cmd_t c;
    logic [31:0] s;
    logic [31:0] p;
    logic [31:0] m;
    logic [3:0] e;
  } wkh_row_t;
  localparam int unsigned STEP = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, st;
  logic wr, rd, hit;
  wkh_ka_t can_ka, iso_ka;
  wkh_filt_t f11, f29;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  time t0, t1;
  wkh_row_t rows [15] = '{
    '{CMD_CAN_SET, 32'h11, 32'h65, 32'hC4648, 4'h0},
    '{CMD_CAN_SET, 32'h11, 32'h65, 32'h4C4648, 4'h7},
    '{CMD_CAN_SET, 32'h31, 32'h65, 32'hC4648, 4'h8},
    '{CMD_CAN_SET, 32'h11, 32'h265, 32'hC4648, 4'h9},
    '{CMD_CAN_SET, 32'h11, 32'h66, 32'hC4648, 4'hA},
    '{CMD_CAN_SET, 32'h12, 32'h100, 32'hC4648, 4'h2},
    '{CMD_CAN_SET, 32'h11, 32'h65, 32'h144648, 4'h3},
    '{CMD_CAN_SET, 32'h11, 32'h65, 32'hC4649, 4'h4},
    '{CMD_CAN_SET, 32'h11, 32'h65, 32'hC4008, 4'h5},
    '{CMD_CAN_SET, 32'h11, 32'h65, 32'hC6648, 4'h6},
    '{CMD_CAN_SET, 32'h11, 32'h65, 32'hC4648, 4'h1},
    '{CMD_ISO_SET, 32'h10, 32'h65, 32'h182646, 4'h4},
    '{CMD_ISO_SET, 32'h10, 32'h65, 32'h184642, 4'h6},
    '{CMD_FILT_SET, 32'h0, 32'h0, 32'hC0000, 4'h0},
    '{CMD_FILT_SET, 32'h0, 32'h0, 32'h200000, 4'h3}
  };

  wkh_host i_wkh_host (.i_core_clk(clk), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  wkh_ctrl #(.STEP_CYC(STEP)) i_wkh_ctrl (.i_core_clk(clk),
    .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_ok(), .o_prompt(),
    .o_can_ka(can_ka), .o_iso_ka(iso_ka), .o_filt11(f11),
    .o_filt29(f29), .o_filtnc());

  initial forever #5 clk = ~clk;

  task automatic chk(input logic [95:0] s, x);
    checks_done++;
    if (s !== x) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // gives up after 1200 cycles so a stopped sequence leaves hit low
  task automatic fire(input bit iso);
    int n;
    n = 0;
    hit = 1'b0;
    @(negedge clk);
    while (hit !== 1'b1 && n < 1200) begin
      @(negedge clk);
      hit = iso ? iso_ka.fire : can_ka.fire;
      n++;
    end
    t0 = t1;
    t1 = $time;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==========
  // sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    i_wkh_host.wr(REG_PDEF_LO, 32'h1);
    i_wkh_host.wr(REG_CTX, 32'h365);
    i_wkh_host.wr(REG_HDR, 32'h7DF);
    i_wkh_host.wr(REG_DLO, 32'h3E01);
    i_wkh_host.wr(REG_MASK, 32'h0FF);
    i_wkh_host.wr(REG_MASKX, 32'h3);
    foreach (rows[i]) begin
      i_wkh_host.cmd(rows[i].c, rows[i].s, rows[i].p, rows[i].m, st);
      chk(st[3:0], rows[i].e);
      chk(st[ST_OK_BIT], rows[i].e == 4'h0);
    end
    chk({f11.id, f11.mask, f29.id}, {29'h7DF, 29'h0FF, 29'h0});
    i_wkh_host.wr(REG_MASKX, 32'h8);
    i_wkh_host.cmd(CMD_FILT_SET, 32'h0, 32'h0, 32'h200000, st);
    chk({st[ST_OK_BIT], f29.id}, {1'b1, 29'h7DF});
    i_wkh_host.wr(REG_MASKX, 32'h16);
    i_wkh_host.cmd(CMD_FILT_SET, 32'h0, 32'h0, 32'h980000, st);
    chk(st[4:0], 5'h03);
    i_wkh_host.rd(8'hFC, st);
    chk(st, 32'h0);
    fire(1'b0);
    fire(1'b0);
    chk((t1 - t0) / 10, 100 * STEP);
    chk({can_ka.id, can_ka.data[15:0]}, {29'h7DF, 16'h3E01});
    i_wkh_host.cmd(CMD_CAN_DEL, 32'h11, 32'h0, 32'h0, st);
    fire(1'b0);
    chk({st[ST_OK_BIT], hit}, 2'b10);
    i_wkh_host.cmd(CMD_ISO_SET, 32'h10, 32'h100, 32'h182642, st);
    fire(1'b1);
    chk({hit, iso_ka.use_default, iso_ka.count}, 6'h22);
    i_wkh_host.cmd(CMD_ISO_DEL, 32'h0, 32'h0, 32'h0, st);
    fire(1'b1);
    chk({hit, iso_ka.use_default}, 2'b11);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    i_wkh_host.cmd(CMD_CAN_SHOW, 32'h10, 32'h0, 32'h0, st);
    chk({st[ST_EMPTY_BIT], f11.id}, {1'b1, 29'h0});
    i_wkh_host.cmd(CMD_ISO_SHOW, 32'h1F, 32'h0, 32'h0, st);
    chk(st[7:4], 4'hD);
    close_out();
  end
endmodule

// ==== verification/wkh_ctrl_properties.sv ====
// checker: answer timing, keepalive pulses and filter stability
// assumes it is bound into wkh_ctrl and sees only its ports
`timescale 1ns/1ps
module wkh_ctrl_chk
  import wkh_pkg::*;
#(
  parameter int unsigned STEP_CYC = KA_STEP_CYC
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  // answers
  input wire logic o_ok,
  input wire logic o_prompt,
  input wire wkh_ka_t o_can_ka,
  input wire wkh_ka_t o_iso_ka,
  input wire wkh_filt_t o_filt11,
  input wire wkh_filt_t o_filtnc
);
  // ==========
  // properties
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  a_prompt_follow: assert property (o_ok |=> o_prompt)
    else $error("no prompt");
  a_prompt_cause: assert property (o_prompt |-> $past(o_ok))
    else $error("stray prompt");
  a_ok_cause: assert property (o_ok |->
    $past(i_wr && (i_addr == REG_CMD || i_addr == REG_SHOW_NEXT), 3))
    else $error("stray ok");
  a_reset_quiet: assert property ($rose(i_rstn) |->
    o_filt11 == '0 && !o_can_ka.fire && !o_iso_ka.fire)
    else $error("not cleared");
  a_filt_cause: assert property ($changed(o_filt11) |->
    ##[0:2] (o_ok || o_prompt))
    else $error("filter moved");
  a_can_gap: assert property ($rose(o_can_ka.fire) |=>
    !o_can_ka.fire [*8])
    else $error("fire too soon");
  a_can_own: assert property (o_can_ka.fire |->
    !o_can_ka.use_default && o_can_ka.count inside {[4'h1:4'h8]})
    else $error("can default");
  a_iso_count: assert property (o_iso_ka.fire &&
    !o_iso_ka.use_default |-> o_iso_ka.count inside {[4'h1:4'h5]})
    else $error("iso count");
  a_nc_noext: assert property (!o_filtnc.ext_en)
    else $error("nc ext");

  c_ok: cover property (o_ok);
  c_can: cover property (o_can_ka.fire);
  c_iso_def: cover property (o_iso_ka.fire && o_iso_ka.use_default);
endmodule

bind wkh_ctrl wkh_ctrl_chk #(.STEP_CYC(STEP_CYC)) i_wkh_ctrl_chk (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr),
  .i_wr(i_wr), .o_ok(o_ok), .o_prompt(o_prompt), .o_can_ka(o_can_ka),
  .o_iso_ka(o_iso_ka), .o_filt11(o_filt11), .o_filtnc(o_filtnc)
);

// ==== verification/wkh_host.sv ====
// host model: loads command arguments over the register port
// assumes one clock; strobes change just after the rising edge
`timescale 1ns/1ps
module wkh_host
  import wkh_pkg::*;
(
  // clock
  input wire logic i_core_clk,
  // register port
  output logic [7:0] o_addr = 8'h00,
  output logic [31:0] o_wdata = 32'h0,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  input wire logic [31:0] i_rdata
);
  // ==========
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask

  // status only settles three edges after the command write
  task automatic cmd(input wkh_cmd_t c, input logic [31:0] s, p, m,
                     output logic [31:0] st);
    if (c == CMD_ISO_SET) m[MISC_HDR_XX_BIT] = 1'b0;
    wr(REG_SLOT, s);
    wr(REG_PROTO, p);
    wr(REG_MISC, m);
    wr(REG_CMD, {29'h0, c});
    repeat (3) @(posedge i_core_clk);
    rd(REG_STATUS, st);
  endtask
endmodule
